//--- acd_host_model.sv
`timescale 1ns/1ns
module acd_host_model (
    output logic      sclk,
    output logic      frameSelectN,
    output logic      serialIn,
    input  wire logic serialOut,
    input  wire logic serialOutEn_n
);
    logic sdoWire;

    // released line is undriven: show the inverse of the data pin, not a held level
    assign sdoWire = serialOutEn_n ? ~serialIn : serialOut;

    initial begin
        sclk = 1'b0;
        frameSelectN = 1'b1;
        serialIn = 1'b0;
    end

    // one frame of nbits clocks at a 6 ns link period, clock idle low outside frames
    task automatic xfer(input logic [15:0] wr, input int nbits, output logic [15:0] rd);
        int i;
        rd = 16'h0000;
        frameSelectN = 1'b0;
        #240;
        for (i = 0; i < nbits; i++) begin
            serialIn = wr[i % 16];
            // sample half a period after the launching fall, just before the rise
            #3;
            if (i < 16) rd[i] = sdoWire;
            sclk = 1'b1;
            #3 sclk = 1'b0;
        end
        #3 frameSelectN = 1'b1;
        serialIn = ~serialIn;
        #320;
    endtask

    // frame select low without clocks: returns {enable, summary}
    task automatic poll(output logic [1:0] v);
        frameSelectN = 1'b0;
        #40 v = {serialOutEn_n, sdoWire};
        frameSelectN = 1'b1;
        #320;
    endtask
endmodule

//--- acd_map.svh
`ifndef ACD_MAP_SVH
`define ACD_MAP_SVH

// frame and control word layout
`define ACD_FRAME_BITS      5'd16
`define ACD_SEL_BIT         0
`define ACD_SUPPLY_HOLD_BIT 12
`define ACD_OC_DUTY_BIT     13
`define ACD_OL_IGNORE_BIT   14
`define ACD_CLR_BIT         15
`define ACD_CTRL_RST        16'h0000

// timing
`define ACD_MCLK_HZ         25000000
`define ACD_INT_CLK_HZ      2000000
`define ACD_INT_CLK_HALF    (`ACD_MCLK_HZ / (2 * `ACD_INT_CLK_HZ))
`define ACD_RECOV_STEP_US   100
`define ACD_RECOV_STEP_CYC  (`ACD_RECOV_STEP_US * (`ACD_MCLK_HZ / 1000000))

`endif

//--- acd_pkg.sv
package acd_pkg;

    typedef enum logic [2:0] {
        CM_NC    = 3'b000,
        CM_TAP1  = 3'b001,
        CM_TAP2  = 3'b010,
        CM_TAP3  = 3'b011,
        CM_TAP4  = 3'b100,
        CM_NC2   = 3'b101,
        CM_IREF  = 3'b110,
        CM_VBG   = 3'b111
    } acd_cm_src_t;

    typedef enum logic [2:0] {
        DO_NOERR  = 3'b000,
        DO_SERIN  = 3'b001,
        DO_SCLK   = 3'b010,
        DO_INTCLK = 3'b011,
        DO_PWM    = 3'b100
    } acd_do_src_t;

endpackage

//--- acd_spi_ctrl.sv
// Functional notes
// - sample on sclk rise, shift out on fall
// - first bit in selects target register
// - write register only after exactly 16 bits
// - shift out status chosen by bit 0
// - bits 1 to 8 switch drivers on
// - bits 9 to 11 pick monitored output
// - valid frame with bit 15 clears status
// - bit 0 is NOR of fault bits
// - over-current flag disables its driver
// - thermal shutdown flag turns all drivers off
// - test mode routes chosen signal to serial out
// - test mode picks monitor pin source
// - test mode lowers over-current threshold fourfold
// - never both switches of one bridge
// - status word zero bit 15 reads one
// - bit 14 masks open-load from summary
// - bit 13 sets recovery duty, warning forces low
// - supply faults set flags, outputs off
// - bit 12 holds outputs off until cleared
// - words travel least significant bit first
// - serial out off while frame select high, except in test mode
// - first rise loads word, falls shift
// - monitor codes 000 to 100 pick outputs
`include "acd_map.svh"
`timescale 1ns/1ns
module acd_spi_ctrl
    import acd_pkg::*;
#(
    parameter int NDRV = 8
) (
    input  wire logic            mclk,
    input  wire logic            rst_n,
    input  wire logic            sclk,
    input  wire logic            frameSelectN,
    input  wire logic            serialIn,
    output logic                 serialOut,
    output logic                 serialOutEn_n,
    input  wire logic            pwmIn,
    input  wire logic            testModeIn,
    input  wire logic [NDRV-1:0] ocDet,
    input  wire logic [NDRV-1:0] olDet,
    input  wire logic            tempWarnDet,
    input  wire logic            tsdDet,
    input  wire logic            ovDet,
    input  wire logic            uvDet,
    input  wire logic            notReadyIn,
    output logic [NDRV-1:0]      driverEn,
    output logic [2:0]           cmOutSel,
    output acd_cm_src_t          cmTestSrc,
    output logic                 ocThrLow
);
    localparam int NASYNC = 2 * NDRV + 7;
    localparam logic [NASYNC-1:0] PIN_RST = {1'b0, 1'b1, {(NASYNC - 2){1'b0}}};

    logic              rstPipe_r;
    logic              rstSync;
    logic [NASYNC-1:0] asyncIn;
    logic [NASYNC-1:0] sync1_r;
    logic [NASYNC-1:0] sync2_r;
    logic [NASYNC-1:0] sync3_r;
    logic [NASYNC-1:0] pinSt_r;
    logic              tmode;
    logic              csnSt;
    logic [NDRV-1:0]   ocLive;
    logic [NDRV-1:0]   olLive;
    logic              twLive;
    logic              tsdLive;
    logic              ovLive;
    logic              uvLive;
    logic              nrdyLive;
    logic              csnPrev_r;
    logic              frameEnd;
    logic              frameStart;
    logic              linkClr_r;
    logic [4:0]        linkCnt_r;
    logic [15:0]       linkShift_r;
    logic              loaded_r;
    logic [15:0]       outWord_r;
    logic [3:0]        outIdx_r;
    logic              validEnd;
    logic              statusClr;
    logic [15:0]       ctrl0_r;
    logic [15:0]       ctrl1_r;
    logic [NDRV-1:0]   ocFlag_r;
    logic [NDRV-1:0]   olFlag_r;
    logic              twFlag_r;
    logic              tsdFlag_r;
    logic              ovFlag_r;
    logic              uvFlag_r;
    logic              no_error_flag_r;
    logic              noErrorNxt;
    logic [15:0]       status0;
    logic [15:0]       status1;
    logic [15:0]       snap0_r;
    logic [15:0]       snap1_r;
    logic [11:0]       stepCnt_r;
    logic [2:0]        phase_r;
    logic              recovOn;
    logic [NDRV-1:0]   ocBlock;
    logic              supplyOff;
    logic [NDRV-1:0]   drvReq;
    logic [NDRV-1:0]   drvEnNxt;
    logic [2:0]        bridgeBoth;
    logic              testMode_r;
    acd_do_src_t       doSrc_r;
    logic [3:0]        intCnt_r;
    logic              intClk_r;
    logic              frameBit;

    // reset release
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_r <= 1'b0;
            rstSync   <= 1'b0;
        end else begin
            rstPipe_r <= 1'b1;
            rstSync   <= rstPipe_r;
        end
    end

    // pin synchronisers, a change counts once stages two and three agree
    assign asyncIn = {testModeIn, frameSelectN, ocDet, olDet, tempWarnDet, tsdDet, ovDet, uvDet, notReadyIn};

    always_ff @(posedge mclk or negedge rstSync) begin
        if (!rstSync) begin
            sync1_r <= PIN_RST;
            sync2_r <= PIN_RST;
            sync3_r <= PIN_RST;
        end else begin
            sync1_r <= asyncIn;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    for (genvar g = 0; g < NASYNC; g++) begin : g_pin
        always_ff @(posedge mclk or negedge rstSync) begin
            if (!rstSync) begin
                pinSt_r[g] <= PIN_RST[g];
            end else if (sync2_r[g] == sync3_r[g]) begin
                pinSt_r[g] <= sync3_r[g];
            end
        end
    end

    assign {tmode, csnSt, ocLive, olLive, twLive, tsdLive, ovLive, uvLive, nrdyLive} = pinSt_r;

    // frame edges; the link side is held cleared between frames
    always_ff @(posedge mclk or negedge rstSync) begin
        if (!rstSync) begin
            csnPrev_r <= 1'b1;
            linkClr_r <= 1'b1;
        end else begin
            csnPrev_r <= csnSt;
            if (frameEnd) begin
                linkClr_r <= 1'b1;
            end else if (frameStart) begin
                linkClr_r <= 1'b0;
            end
        end
    end

    assign frameEnd   = csnSt & ~csnPrev_r;
    assign frameStart = ~csnSt & csnPrev_r;

    // link domain: bit counter and input shifter, lsb arrives first
    always_ff @(posedge sclk or posedge linkClr_r) begin
        if (linkClr_r) begin
            linkCnt_r   <= 5'd0;
            linkShift_r <= 16'h0000;
        end else begin
            if (linkCnt_r != 5'h1f) begin
                linkCnt_r <= linkCnt_r + 5'd1;
            end
            linkShift_r <= {serialIn, linkShift_r[15:1]};
        end
    end

    // first rising edge loads the status word picked by the incoming bit 0
    always_ff @(posedge sclk or posedge linkClr_r) begin
        if (linkClr_r) begin
            loaded_r  <= 1'b0;
            outWord_r <= 16'h0000;
        end else if (!loaded_r) begin
            loaded_r  <= 1'b1;
            outWord_r <= serialIn ? snap1_r : snap0_r;
        end
    end

    always_ff @(negedge sclk or posedge linkClr_r) begin
        if (linkClr_r) begin
            outIdx_r <= 4'h0;
        end else if (loaded_r) begin
            outIdx_r <= outIdx_r + 4'h1;
        end
    end

    // serial out: summary bit until the word is loaded
    assign frameBit = loaded_r ? outWord_r[outIdx_r] : no_error_flag_r;

    always_comb begin
        serialOut = frameBit;
        if (testMode_r) begin
            case (doSrc_r)
                DO_SERIN:  serialOut = serialIn;
                DO_SCLK:   serialOut = sclk;
                DO_INTCLK: serialOut = intClk_r;
                DO_PWM:    serialOut = pwmIn;
                default:   serialOut = no_error_flag_r;
            endcase
        end
    end

    assign serialOutEn_n = frameSelectN & ~testMode_r;

    // frame acceptance
    assign validEnd  = frameEnd && (linkCnt_r == `ACD_FRAME_BITS);
    assign statusClr = validEnd && linkShift_r[`ACD_CLR_BIT];

    always_ff @(posedge mclk or negedge rstSync) begin
        if (!rstSync) begin
            ctrl0_r <= `ACD_CTRL_RST;
            ctrl1_r <= `ACD_CTRL_RST;
        end else if (validEnd) begin
            if (linkShift_r[`ACD_SEL_BIT]) begin
                ctrl1_r <= linkShift_r;
            end else begin
                ctrl0_r <= linkShift_r;
            end
        end
    end

    // sticky fault flags, a new event wins over a clear
    always_ff @(posedge mclk or negedge rstSync) begin
        if (!rstSync) begin
            ocFlag_r  <= '0;
            olFlag_r  <= '0;
            twFlag_r  <= 1'b0;
            tsdFlag_r <= 1'b0;
            ovFlag_r  <= 1'b0;
            uvFlag_r  <= 1'b0;
        end else begin
            ocFlag_r  <= (ocFlag_r & {NDRV{~statusClr}}) | ocLive;
            olFlag_r  <= (olFlag_r & {NDRV{~statusClr}}) | olLive;
            twFlag_r  <= (twFlag_r & ~statusClr) | twLive;
            tsdFlag_r <= (tsdFlag_r & ~statusClr) | tsdLive;
            ovFlag_r  <= (ovFlag_r & ~statusClr) | ovLive;
            uvFlag_r  <= (uvFlag_r & ~statusClr) | uvLive;
        end
    end

    assign status0 = {1'b1, ovFlag_r, uvFlag_r, tsdFlag_r, twFlag_r, nrdyLive, 1'b0, ocFlag_r, no_error_flag_r};
    assign status1 = {7'h00, olFlag_r, no_error_flag_r};

    assign noErrorNxt = ~(|status0[14:1] | |(olFlag_r & {NDRV{~ctrl0_r[`ACD_OL_IGNORE_BIT]}}));

    // status snapshots stay frozen while a frame is open
    always_ff @(posedge mclk or negedge rstSync) begin
        if (!rstSync) begin
            no_error_flag_r <= 1'b1;
            snap0_r   <= 16'h8001;
            snap1_r   <= 16'h0001;
        end else begin
            no_error_flag_r <= noErrorNxt;
            if (csnSt && !frameEnd) begin
                snap0_r <= status0;
                snap1_r <= status1;
            end
        end
    end

    // over-current recovery: on for one or two of eight steps
    always_ff @(posedge mclk or negedge rstSync) begin
        if (!rstSync) begin
            stepCnt_r <= 12'h000;
            phase_r   <= 3'h0;
        end else if (stepCnt_r == 12'(`ACD_RECOV_STEP_CYC - 1)) begin
            stepCnt_r <= 12'h000;
            phase_r   <= phase_r + 3'h1;
        end else begin
            stepCnt_r <= stepCnt_r + 12'h001;
        end
    end

    assign recovOn = (phase_r == 3'h0) ||
                     (ctrl0_r[`ACD_OC_DUTY_BIT] && !twFlag_r && phase_r == 3'h1);
    assign ocBlock = ocFlag_r & ~(ctrl1_r[NDRV:1] & {NDRV{recovOn}});

    assign supplyOff = ovLive | uvLive | (ctrl0_r[`ACD_SUPPLY_HOLD_BIT] & (ovFlag_r | uvFlag_r));
    assign drvReq    = ctrl0_r[NDRV:1] & ~ocBlock & {NDRV{~(tsdFlag_r | supplyOff)}};

    // half-bridges sit on driver pairs (0,1) (2,3) (4,5)
    always_comb begin
        drvEnNxt = drvReq;
        for (int k = 0; k < 3; k++) begin
            if (drvReq[2 * k] && drvReq[2 * k + 1]) begin
                drvEnNxt[2 * k]     = 1'b0;
                drvEnNxt[2 * k + 1] = 1'b0;
            end
        end
    end

    for (genvar b = 0; b < 3; b++) begin : g_bridge
        assign bridgeBoth[b] = ctrl0_r[2 * b + 1] & ctrl0_r[2 * b + 2];
    end

    // output and test selections
    always_ff @(posedge mclk or negedge rstSync) begin
        if (!rstSync) begin
            driverEn   <= '0;
            cmOutSel   <= 3'h0;
            cmTestSrc  <= CM_NC;
            doSrc_r    <= DO_NOERR;
            testMode_r <= 1'b0;
            ocThrLow   <= 1'b0;
        end else begin
            driverEn   <= drvEnNxt;
            cmOutSel   <= ctrl0_r[11:9];
            testMode_r <= tmode;
            ocThrLow   <= tmode;
            cmTestSrc  <= tmode ? acd_cm_src_t'(bridgeBoth) : CM_NC;
            case (bridgeBoth)
                3'b001:  doSrc_r <= DO_SERIN;
                3'b010:  doSrc_r <= DO_SCLK;
                3'b011:  doSrc_r <= DO_INTCLK;
                3'b100:  doSrc_r <= DO_PWM;
                default: doSrc_r <= DO_NOERR;
            endcase
        end
    end

    // internal clock, mclk divided by 12 (about 2.08 MHz)
    always_ff @(posedge mclk or negedge rstSync) begin
        if (!rstSync) begin
            intCnt_r <= 4'h0;
            intClk_r <= 1'b0;
        end else if (intCnt_r == 4'(`ACD_INT_CLK_HALF - 1)) begin
            intCnt_r <= 4'h0;
            intClk_r <= ~intClk_r;
        end else begin
            intCnt_r <= intCnt_r + 4'h1;
        end
    end

    property p_write_ctrl0;
        @(posedge mclk) disable iff (!rstSync)
        validEnd && !linkShift_r[0] |=> ctrl0_r == $past(linkShift_r);
    endproperty
    a_write_ctrl0: assert property (p_write_ctrl0) else $error("control word zero not written");

    property p_bad_frame;
        @(posedge mclk) disable iff (!rstSync)
        frameEnd && linkCnt_r != 5'd16 |=> $stable(ctrl0_r) && $stable(ctrl1_r) && !$past(statusClr);
    endproperty
    a_bad_frame: assert property (p_bad_frame) else $error("bad frame changed state");

    property p_clear_tsd;
        @(posedge mclk) disable iff (!rstSync)
        statusClr && !tsdLive |=> !tsdFlag_r;
    endproperty
    a_clear_tsd: assert property (p_clear_tsd) else $error("thermal flag not cleared");

    property p_summary;
        @(posedge mclk) disable iff (!rstSync)
        (ovFlag_r || tsdFlag_r || ocFlag_r != '0) ##1 1'b1 |-> !no_error_flag_r;
    endproperty
    a_summary: assert property (p_summary) else $error("summary bit high with fault");

    sequence s_tsd_held;
        tsdFlag_r [*2];
    endsequence
    property p_tsd_off;
        @(posedge mclk) disable iff (!rstSync)
        s_tsd_held |-> driverEn == '0;
    endproperty
    a_tsd_off: assert property (p_tsd_off) else $error("driver on in thermal shutdown");

    property p_bridge;
        @(posedge mclk) disable iff (!rstSync)
        !(driverEn[0] && driverEn[1]) && !(driverEn[2] && driverEn[3]) && !(driverEn[4] && driverEn[5]);
    endproperty
    a_bridge: assert property (p_bridge) else $error("both switches of a bridge on");

    property p_word0_top;
        @(posedge mclk) disable iff (!rstSync)
        snap0_r[15] && status0[15];
    endproperty
    a_word0_top: assert property (p_word0_top) else $error("status word zero bit 15 low");

    property p_thr_low;
        @(posedge mclk) disable iff (!rstSync)
        $rose(tmode) |=> ocThrLow ##1 ocThrLow;
    endproperty
    a_thr_low: assert property (p_thr_low) else $error("threshold not lowered in test mode");

    property p_oc_off;
        @(posedge mclk) disable iff (!rstSync)
        (ocFlag_r & ~ctrl1_r[NDRV:1]) != '0 |=> (driverEn & $past(ocFlag_r & ~ctrl1_r[NDRV:1])) == '0;
    endproperty
    a_oc_off: assert property (p_oc_off) else $error("driver on with over-current flag");

    property p_supply_off;
        @(posedge mclk) disable iff (!rstSync)
        ovLive || uvLive |=> ovFlag_r || uvFlag_r ##0 driverEn == '0;
    endproperty
    a_supply_off: assert property (p_supply_off) else $error("outputs on during supply fault");

    property p_cm_sel;
        @(posedge mclk) disable iff (!rstSync)
        1'b1 |=> cmOutSel == $past(ctrl0_r[11:9]);
    endproperty
    a_cm_sel: assert property (p_cm_sel) else $error("monitor select wrong");

endmodule

//--- tb_actuator_driver_spi_control.sv
`timescale 1ns/1ns
module tb_actuator_driver_spi_control;
    import acd_pkg::*;

    logic        mclk;
    logic        rst_n;
    logic        sclk;
    logic        frameSelectN;
    logic        serialIn;
    logic        serialOut;
    logic        serialOutEn_n;
    logic        pwmIn;
    logic        testModeIn;
    logic [7:0]  ocDet;
    logic [7:0]  olDet;
    logic        tempWarnDet;
    logic        tsdDet;
    logic        ovDet;
    logic        uvDet;
    logic        notReadyIn;
    logic [7:0]  driverEn;
    logic [2:0]  cmOutSel;
    acd_cm_src_t cmTestSrc;
    logic        ocThrLow;
    logic [15:0] rdData;
    logic [1:0]  pollVal;
    int          numErrors;
    int          testsRun;
    int          cycles;

    acd_spi_ctrl i_acd_spi_ctrl (
        .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .frameSelectN(frameSelectN),
        .serialIn(serialIn), .serialOut(serialOut), .serialOutEn_n(serialOutEn_n),
        .pwmIn(pwmIn), .testModeIn(testModeIn), .ocDet(ocDet), .olDet(olDet),
        .tempWarnDet(tempWarnDet), .tsdDet(tsdDet), .ovDet(ovDet), .uvDet(uvDet),
        .notReadyIn(notReadyIn), .driverEn(driverEn), .cmOutSel(cmOutSel),
        .cmTestSrc(cmTestSrc), .ocThrLow(ocThrLow)
    );

    acd_host_model i_acd_host_model (
        .sclk(sclk), .frameSelectN(frameSelectN), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEn_n(serialOutEn_n)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic report_and_stop;
        if (numErrors == 0 && testsRun > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        testsRun++;
        if (seen !== exp) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic settle;
        repeat (10) @(negedge mclk);
    endtask

    task automatic frame(input logic [15:0] wr, input int n);
        @(negedge mclk);
        #7 i_acd_host_model.xfer(wr, n, rdData);
        repeat (12) @(negedge mclk);
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            numErrors++;
            report_and_stop();
        end
    end

    initial begin
        logic [15:0] pat [2];
        pat[0] = 16'h0006;
        pat[1] = 16'h0060;
        rst_n = 1'b0;
        pwmIn = 1'b0;
        testModeIn = 1'b0;
        ocDet = 8'h00;
        olDet = 8'h00;
        tempWarnDet = 1'b0;
        tsdDet = 1'b0;
        ovDet = 1'b0;
        uvDet = 1'b0;
        notReadyIn = 1'b0;
        repeat (8) @(posedge mclk);
        @(negedge mclk) rst_n = 1'b1;
        settle();
        check("drv_rst", driverEn, 16'h0000);
        check("cm_rst", cmOutSel, 16'h0000);
        check("thr_rst", ocThrLow, 16'h0000);
        check("oe_idle", serialOutEn_n, 16'h0001);
        // drivers 0x9a, monitor code 100
        frame(16'h0934, 16);
        check("st0_clean", rdData, 16'h8001);
        check("drv", driverEn, 16'h009a);
        check("cm", cmOutSel, 16'h0004);
        frame(16'h0002, 15);
        frame(16'h0002, 17);
        check("drv_badlen", driverEn, 16'h009a);
        frame(16'h0006, 16);
        check("bridge", driverEn[1:0] == 2'b11, 16'h0000);
        check("cm_new", cmOutSel, 16'h0000);
        // over-current on driver 3 with warning and not-ready
        frame(16'h0134, 16);
        ocDet[3] = 1'b1;
        tempWarnDet = 1'b1;
        notReadyIn = 1'b1;
        settle();
        check("drv_oc", driverEn, 16'h0092);
        i_acd_host_model.poll(pollVal);
        check("poll", pollVal, 16'h0000);
        frame(16'h0134, 16);
        check("st0_oc", rdData, 16'h8c10);
        ocDet = 8'h00;
        tempWarnDet = 1'b0;
        notReadyIn = 1'b0;
        settle();
        check("drv_oc_hold", driverEn, 16'h0092);
        frame(16'h8134, 15);
        check("drv_badclr", driverEn, 16'h0092);
        frame(16'h8134, 16);
        check("drv_clr", driverEn, 16'h009a);
        frame(16'h0134, 16);
        check("st0_clr", rdData, 16'h8001);
        // thermal shutdown
        tsdDet = 1'b1;
        settle();
        check("drv_tsd", driverEn, 16'h0000);
        tsdDet = 1'b0;
        settle();
        frame(16'h0134, 16);
        check("st0_tsd", rdData, 16'h9000);
        check("drv_tsd_hold", driverEn, 16'h0000);
        frame(16'h8134, 16);
        check("drv_tsd_clr", driverEn, 16'h009a);
        // supply faults, automatic and held recovery
        uvDet = 1'b1;
        settle();
        check("drv_uv", driverEn, 16'h0000);
        frame(16'h0134, 16);
        check("st0_uv", rdData, 16'ha000);
        uvDet = 1'b0;
        settle();
        check("drv_uv_auto", driverEn, 16'h009a);
        frame(16'h9134, 16);
        ovDet = 1'b1;
        settle();
        check("drv_ov", driverEn, 16'h0000);
        ovDet = 1'b0;
        settle();
        check("drv_ov_hold", driverEn, 16'h0000);
        frame(16'h9134, 16);
        check("st0_ov", rdData, 16'hc000);
        check("drv_ov_clr", driverEn, 16'h009a);
        // recovery enabled for driver 3; still inside the first recovery step
        frame(16'h0011, 16);
        ocDet[3] = 1'b1;
        settle();
        check("drv_recov", driverEn, 16'h009a);
        ocDet = 8'h00;
        frame(16'h8134, 16);
        // open-load, then masked from the summary
        olDet[0] = 1'b1;
        settle();
        frame(16'h0001, 16);
        check("st1_ol", rdData, 16'h0002);
        frame(16'h4134, 16);
        frame(16'h0001, 16);
        check("st1_olmask", rdData, 16'h0003);
        olDet = 8'h00;
        frame(16'h8134, 16);
        // test mode
        testModeIn = 1'b1;
        settle();
        check("thr_test", ocThrLow, 16'h0001);
        check("oe_test", serialOutEn_n, 16'h0000);
        frame(16'h0000, 16);
        check("do_noerr", serialOut, 16'h0001);
        for (int k = 0; k < 2; k++) begin
            frame(pat[k], 16);
            check("cm_test", cmTestSrc, (k == 0) ? 16'h0001 : 16'h0004);
        end
        pwmIn = 1'b1;
        settle();
        check("do_pwm_hi", serialOut, 16'h0001);
        pwmIn = 1'b0;
        settle();
        check("do_pwm_lo", serialOut, 16'h0000);
        testModeIn = 1'b0;
        settle();
        check("thr_norm", ocThrLow, 16'h0000);
        check("cm_norm", cmTestSrc, 16'h0000);
        report_and_stop();
    end
endmodule
